//--- src/rcn_pkg.sv
// Package of constants for the receive coarse NCO with dual modulus
package rcn_pkg;
    localparam int PHASE_WIDTH = 48;
    localparam logic [47:0] WORD_ZERO = 48'h0000_0000_0000;
    localparam logic [47:0] PHASE_LSB = 48'h0000_0000_0001;
    typedef enum logic {RCN_INTEGER, RCN_DUAL_MODULUS} rcn_mode_e;
endpackage : rcn_pkg

//--- src/rcn_frac_acc.sv
// Fractional accumulator: numerator added modulo the denominator, carry out
`timescale 1ns/1ps
`default_nettype none
module rcn_frac_acc #(
    parameter int WIDTH = rcn_pkg::PHASE_WIDTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic clear,
    input wire logic [WIDTH-1:0] numerator,
    input wire logic [WIDTH-1:0] denominator,
    output logic carry
);
    import rcn_pkg::*;

    logic [WIDTH-1:0] residue;
    logic [WIDTH:0] sum;
    logic [WIDTH:0] wrapped;
    logic wrap;
    logic [WIDTH-1:0] next_residue;

    // Sum one bit wider, so a large numerator cannot overflow silently
    assign sum = {1'b0, residue} + {1'b0, numerator};
    assign wrap = (numerator != WORD_ZERO) && (sum >= {1'b0, denominator});
    assign wrapped = sum - {1'b0, denominator};
    assign next_residue = wrap ? wrapped[WIDTH-1:0] : sum[WIDTH-1:0];

    // Residue and carry register, carry marks one extra phase LSB
    always_ff @(posedge core_clk) begin
        if (reset || clear) begin
            residue <= WORD_ZERO;
            carry <= 1'b0;
        end else if (clkEn) begin
            residue <= next_residue;
            carry <= wrap;
        end
    end

    AST_RESIDUE_BOUNDED: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !clear && $past(clkEn) && numerator != WORD_ZERO && numerator < denominator
            && $stable(denominator) && $stable(numerator) && residue < denominator)
            |=> residue < $past(denominator))
        else $error("Residue not below denominator");
endmodule : rcn_frac_acc
`default_nettype wire

//--- src/rcn_nco.sv
// Receive coarse NCO top: staged words, phase accumulator, mode select
`timescale 1ns/1ps
`default_nettype none
module rcn_nco #(
    parameter int WIDTH = rcn_pkg::PHASE_WIDTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic softReset,
    input wire logic [WIDTH-1:0] phase_step_integer,
    input wire logic [WIDTH-1:0] phase_step_frac_numerator,
    input wire logic [WIDTH-1:0] phase_step_frac_denominator,
    input wire logic [WIDTH-1:0] phase_offset_word,
    input wire logic transferStrobe,
    output logic [WIDTH-1:0] phase_accumulator_value,
    output logic [WIDTH-1:0] ncoPhase,
    output logic transferDone,
    output rcn_pkg::rcn_mode_e ncoMode
);
    import rcn_pkg::*;

    // Active word set, loaded together on a transfer
    logic [WIDTH-1:0] stepActive;
    logic [WIDTH-1:0] numActive;
    logic [WIDTH-1:0] denActive;
    logic [WIDTH-1:0] offsetActive;
    logic fracCarry;
    logic [WIDTH-1:0] stepTotal;
    logic [WIDTH-1:0] next_acc;
    logic [WIDTH-1:0] next_phase;
    rcn_mode_e next_mode;
    logic accClear;

    assign accClear = softReset;
    // Mode follows the active numerator only
    assign next_mode = (numActive != WORD_ZERO) ? RCN_DUAL_MODULUS : RCN_INTEGER;
    // Step is two's complement, modular add wraps to alias within the sample rate
    assign stepTotal = fracCarry ? stepActive + PHASE_LSB : stepActive;
    assign next_acc = phase_accumulator_value + stepTotal;
    assign next_phase = next_acc + offsetActive;

    // Staging: all four words move in the same cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stepActive <= WORD_ZERO;
            numActive <= WORD_ZERO;
            denActive <= WORD_ZERO;
            offsetActive <= WORD_ZERO;
            transferDone <= 1'b0;
        end else if (clkEn) begin
            transferDone <= transferStrobe;
            if (transferStrobe) begin
                stepActive <= phase_step_integer;
                numActive <= phase_step_frac_numerator;
                denActive <= phase_step_frac_denominator;
                offsetActive <= phase_offset_word;
            end
        end
    end

    // Phase accumulator; step change keeps the running phase (coherent in integer mode)
    always_ff @(posedge core_clk) begin
        if (reset || accClear) begin
            phase_accumulator_value <= WORD_ZERO;
            ncoPhase <= WORD_ZERO; // Offset is not applied while held in clear
            ncoMode <= RCN_INTEGER;
        end else if (clkEn) begin
            phase_accumulator_value <= next_acc;
            ncoPhase <= next_phase;
            ncoMode <= next_mode;
        end
    end

    rcn_frac_acc #(
        .WIDTH(WIDTH)
    ) uFrac (
        .core_clk(core_clk),
        .reset(reset),
        .clkEn(clkEn),
        .clear(accClear),
        .numerator(numActive),
        .denominator(denActive),
        .carry(fracCarry)
    );

    // Integer operation: every enabled cycle adds the step alone
    AST_INTEGER_STEP: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && numActive == WORD_ZERO && $past(numActive) == WORD_ZERO)
            |=> phase_accumulator_value == $past(phase_accumulator_value + stepActive))
        else $error("Integer step not applied");

    // A registered carry adds one extra LSB at the following edge
    AST_CARRY_STEP: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && fracCarry)
            |=> phase_accumulator_value == $past(phase_accumulator_value + stepActive + PHASE_LSB))
        else $error("Carry LSB missing");

    // Mode register follows the active numerator one cycle later
    AST_MODE_DUAL: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && numActive != WORD_ZERO) |=> ncoMode == RCN_DUAL_MODULUS)
        else $error("Dual modulus mode not entered");

    AST_MODE_INT: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && numActive == WORD_ZERO) |=> ncoMode == RCN_INTEGER)
        else $error("Integer mode not selected");

    // Soft reset returns the accumulator to zero
    AST_ACC_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
        accClear |=> phase_accumulator_value == WORD_ZERO)
        else $error("Accumulator not cleared");

    // Step, numerator and denominator land in the same cycle, together with the done pulse
    AST_TRANSFER: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && transferStrobe) |=> stepActive == $past(phase_step_integer)
            && numActive == $past(phase_step_frac_numerator)
            && denActive == $past(phase_step_frac_denominator) && transferDone)
        else $error("Transfer not applied together");

    // Without a transfer the active step and numerator must not move
    AST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !transferStrobe) |=> $stable(stepActive) && $stable(numActive))
        else $error("Active words changed without transfer");

    // Clock enable low freezes the accumulator
    AST_FREEZE: assert property (@(posedge core_clk) disable iff (reset)
        (!clkEn && !accClear) |=> $stable(phase_accumulator_value))
        else $error("Accumulator moved while frozen");

    // Named steps of a transfer and of the mode switch that follows it
    sequence seqEnabled;
        clkEn && !accClear;
    endsequence

    sequence seqXferTaken;
        clkEn && transferStrobe;
    endsequence

    sequence seqXferLoaded;
        transferDone && offsetActive == $past(phase_offset_word);
    endsequence

    sequence seqFracLoaded;
        clkEn && transferStrobe && phase_step_frac_numerator != WORD_ZERO;
    endsequence

    sequence seqIntLoaded;
        clkEn && transferStrobe && phase_step_frac_numerator == WORD_ZERO;
    endsequence

    // The offset travels with the other words and the done pulse marks it
    AST_XFER_OFFSET: assert property (@(posedge core_clk) disable iff (reset)
        seqXferTaken |=> seqXferLoaded)
        else $error("Offset not transferred with the set");

    // Done is a single pulse, never raised without a taken transfer
    AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !transferStrobe) |=> !transferDone)
        else $error("Transfer done without a transfer");

    // Loading a nonzero numerator reaches dual modulus two edges later
    AST_ENTER_DUAL: assert property (@(posedge core_clk) disable iff (reset)
        seqFracLoaded ##1 seqEnabled |=> ncoMode == RCN_DUAL_MODULUS)
        else $error("Loaded numerator did not select dual modulus");

    // Loading a zero numerator returns to integer operation
    AST_ENTER_INT: assert property (@(posedge core_clk) disable iff (reset)
        seqIntLoaded ##1 seqEnabled |=> ncoMode == RCN_INTEGER)
        else $error("Zero numerator did not select integer mode");

    // Integer operation never produces a fractional carry
    AST_NO_CARRY_INT: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && numActive == WORD_ZERO) |=> !fracCarry)
        else $error("Carry seen in integer mode");

    // Zero denominator with a nonzero numerator carries every cycle
    AST_CARRY_DEN_ZERO: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && numActive != WORD_ZERO && denActive == WORD_ZERO)
            |=> fracCarry)
        else $error("Carry missing with zero denominator");

    // Phase output is the new accumulator plus the offset of the cycle before
    AST_PHASE_OFFSET: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear)
            |=> ncoPhase == phase_accumulator_value + $past(offsetActive))
        else $error("Phase output not offset from accumulator");

    // Soft reset clears phase, mode and carry together
    AST_CLEAR_OUTPUTS: assert property (@(posedge core_clk) disable iff (reset)
        accClear |=> ncoPhase == WORD_ZERO && ncoMode == RCN_INTEGER && !fracCarry)
        else $error("Outputs not cleared by soft reset");

    // A step change in integer mode continues from the running phase
    AST_COHERENT: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && numActive == WORD_ZERO && $past(numActive) == WORD_ZERO
            && $changed(stepActive))
            |=> phase_accumulator_value == $past(phase_accumulator_value + stepActive))
        else $error("Phase jumped on integer step change");

    // A negative step moves the phase backwards by its magnitude
    AST_STEP_TWOS: assert property (@(posedge core_clk) disable iff (reset)
        (clkEn && !accClear && !fracCarry && stepActive[WIDTH-1])
            |=> phase_accumulator_value
                == $past(phase_accumulator_value) - ($past(~stepActive) + PHASE_LSB))
        else $error("Negative step not applied as two's complement");

    // First edge after reset shows every output at zero
    AST_RESET_OUTPUTS: assert property (@(posedge core_clk) disable iff (reset)
        $fell(reset) |-> phase_accumulator_value == WORD_ZERO && ncoPhase == WORD_ZERO
            && !transferDone && ncoMode == RCN_INTEGER)
        else $error("Outputs not zero after reset");

    // Clock enable low also freezes the active set
    AST_FREEZE_WORDS: assert property (@(posedge core_clk) disable iff (reset)
        !clkEn |=> $stable(stepActive) && $stable(numActive)
            && $stable(denActive) && $stable(offsetActive))
        else $error("Active words moved while frozen");

    // Clock enable low freezes the remaining outputs
    AST_FREEZE_OUTPUTS: assert property (@(posedge core_clk) disable iff (reset)
        (!clkEn && !accClear)
            |=> $stable(ncoPhase) && $stable(ncoMode) && $stable(transferDone))
        else $error("Outputs moved while frozen");
endmodule : rcn_nco
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the receive coarse NCO
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rcn_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic softReset = 1'b0;
    logic transferStrobe = 1'b0;
    logic [47:0] stepWord = 48'h0, numWord = 48'h0, denWord = 48'h0, offWord = 48'h0;
    logic [47:0] accValue, ncoPhase;
    logic transferDone;
    rcn_mode_e ncoMode;
    int errors = 0;
    int nTests = 0;
    rcn_nco DUT (.core_clk(core_clk), .reset(reset), .clkEn(clkEn), .softReset(softReset),
        .phase_step_integer(stepWord), .phase_step_frac_numerator(numWord),
        .phase_step_frac_denominator(denWord), .phase_offset_word(offWord),
        .transferStrobe(transferStrobe), .phase_accumulator_value(accValue),
        .ncoPhase(ncoPhase), .transferDone(transferDone), .ncoMode(ncoMode));
    // Clock at 100 MHz
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] expected);
        nTests++;
        if (seen !== expected) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    // Advance over len cycles: one carry per cycle with a zero denominator
    function automatic logic [47:0] expAdvance(input logic [47:0] s, n, d, input int len);
        logic [47:0] carries;
        carries = (n == 48'h0) ? 48'h0 : ((d == 48'h0) ? 48'(len) : n);
        return s * 48'(len) + carries;
    endfunction
    // Load a word set, then watch the accumulator over a whole modulus period, or 8 cycles when the numerator or denominator is zero
    task automatic run(input logic [47:0] s, n, d, o);
        logic [47:0] startAcc, prevAcc;
        int len;
        @(posedge core_clk);
        stepWord <= s;
        numWord <= n;
        denWord <= d;
        offWord <= o;
        transferStrobe <= 1'b1;
        @(posedge core_clk);
        transferStrobe <= 1'b0;
        #1;
        check({47'h0, transferDone}, 48'h1);
        @(posedge core_clk);
        softReset <= (n != 48'h0);
        @(posedge core_clk);
        softReset <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({47'h0, transferDone}, 48'h0);
        check({47'h0, ncoMode}, {47'h0, n != 48'h0});
        len = (n == 48'h0 || d == 48'h0) ? 8 : int'(d);
        startAcc = accValue;
        for (int i = 0; i < len; i++) begin
            prevAcc = accValue;
            @(posedge core_clk);
            #1;
            check(ncoPhase - accValue, o);
            if (n == 48'h0) check(accValue - prevAcc, s);
        end
        check(accValue - startAcc, expAdvance(s, n, d, len));
        $display("Test done: step %h num %h den %h", s, n, d);
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the longest modulus period
    initial begin
        repeat (30000) @(posedge core_clk);
        errors++;
        results();
    end
    // Main sequence: corners, then random word sets
    initial begin
        logic [47:0] rs, rn, rd;
        void'($urandom(32'h2f0432b5));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        check(accValue, WORD_ZERO);
        check({47'h0, ncoMode}, 48'h0);
        run(48'h8000_0000_0000, WORD_ZERO, WORD_ZERO, 48'h0000_0000_0010);
        run(48'h7FFF_FFFF_FFFF, WORD_ZERO, 48'h0000_0000_0005, 48'hFFFF_0000_0000);
        run(48'h5576_19F0_FB38, 48'h0000_0000_0F80, 48'h0000_0000_1770, WORD_ZERO);
        run(48'h0000_0000_0100, 48'h0000_0000_0003, WORD_ZERO, PHASE_LSB);
        for (int r = 0; r < 8; r++) begin
            rs = 48'({$urandom, $urandom}) & 48'hFFFF_FFFF_FFFC;
            rd = 48'(2 + $urandom % 300);
            rn = (r % 3 == 0) ? WORD_ZERO : 48'(1 + $urandom % (rd - 1));
            run(rs, rn, rd, 48'({$urandom, $urandom}));
        end
        // Clock enable low freezes the accumulator
        @(posedge core_clk);
        clkEn <= 1'b0;
        @(posedge core_clk);
        #1;
        rs = accValue;
        repeat (3) @(posedge core_clk);
        #1;
        check(accValue, rs);
        $display("Test done: clock enable freeze");
        // Soft reset holds the accumulator at zero
        @(posedge core_clk);
        clkEn <= 1'b1;
        softReset <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check(accValue, WORD_ZERO);
        $display("Test done: soft reset hold");
        @(posedge core_clk);
        softReset <= 1'b0;
        run(48'h0000_0000_0040, 48'h0000_0000_0001, 48'h0000_0000_0003, WORD_ZERO);
        results();
    end
endmodule // testbench
`default_nettype wire
